// ===== dv/capture_compare_pwm_timer_test.sv
`timescale 1ns/10ps
module capture_compare_pwm_timer_test;
   logic        clk_i   = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [3:0]  addr    = 4'h0;
   logic [15:0] wdata   = 16'h0000;
   logic        wr      = 1'b0;
   logic        rd      = 1'b0;
   logic        cap     = 1'b0;
   logic [15:0] rdata;
   logic [3:0]  pin_o;
   logic [3:0]  oe_n;
   logic [3:0]  pin_lvl;
   logic        irq;
   logic [15:0] v;
   logic [15:0] a0;
   logic [15:0] a1;
   int          failures  = 0;
   int          tests_run = 0;
   int          cycles    = 0;
   int          hi;
   int          fl;
   always #2.5 clk_i = ~clk_i;
   ccpt_timer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .timer_pin_i(pin_lvl),
      .timer_pin_o(pin_o), .timer_pin_oe_n_o(oe_n), .irq_o(irq));
   ccpt_pin_model u_pins (.cap_lvl_i(cap), .pin_o_i(pin_o), .oe_n_i(oe_n), .pin_level_o(pin_lvl));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (failures == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic watch(input int len, output int highs, output int flips);
      logic last;
      highs = 0;
      flips = 0;
      // Start past the edge so the window spans exactly len edges
      #1;
      last = pin_o[1];
      repeat (len) begin
         @(posedge clk_i);
         #1;
         highs += (pin_o[1] === 1'b1);
         flips += (pin_o[1] !== last);
         last = pin_o[1];
      end
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1;
      check({12'h000, oe_n}, 16'h000f);
      rd_reg(ccpt_pkg::MODE_OFS, v); check(v, 16'h0040);
      rd_reg(ccpt_pkg::ODIS_OFS, v); check(v, 16'h000f);
      rd_reg(ccpt_pkg::GR_A_OFS, v); check(v, 16'hffff);
      rd_reg(4'hc, v); check(v, 16'h0000);
      repeat (4) @(posedge clk_i);
      rd_reg(ccpt_pkg::CNT_OFS, v); check(v, 16'h0000);
      wr_reg(ccpt_pkg::IEN_OFS, 16'h0080);
      wr_reg(ccpt_pkg::CNT_OFS, 16'hfffd);
      wr_reg(ccpt_pkg::MODE_OFS, 16'h00c0);
      repeat (8) @(posedge clk_i);
      rd_reg(ccpt_pkg::STAT_OFS, v); check(v & 16'h0080, 16'h0080);
      check({15'h0, irq}, 16'h0001);
      wr_reg(ccpt_pkg::IEN_OFS, 16'h0000);
      repeat (2) @(posedge clk_i);
      #1;
      check({15'h0, irq}, 16'h0000);
      wr_reg(ccpt_pkg::STAT_OFS, 16'h00ff);
      rd_reg(ccpt_pkg::STAT_OFS, v); check(v & 16'h0080, 16'h0000);
      // Clear on match A before the counter runs, giving an 8-cycle period
      wr_reg(ccpt_pkg::MODE_OFS, 16'h0040);
      wr_reg(ccpt_pkg::CTRL_OFS, 16'h0080);
      wr_reg(ccpt_pkg::ODIS_OFS, 16'h0000);
      wr_reg(ccpt_pkg::IO0_OFS, 16'h0001);
      wr_reg(ccpt_pkg::IO1_OFS, 16'h0001);
      wr_reg(ccpt_pkg::GR_C_OFS, 16'h0005);
      wr_reg(ccpt_pkg::GR_A_OFS, 16'h0007);
      wr_reg(ccpt_pkg::GR_B_OFS, 16'h0003);
      wr_reg(ccpt_pkg::CNT_OFS, 16'h0000);
      wr_reg(ccpt_pkg::STAT_OFS, 16'h00ff);
      wr_reg(ccpt_pkg::IEN_OFS, 16'h0001);
      wr_reg(ccpt_pkg::MODE_OFS, 16'h00c0);
      repeat (6) begin
         rd_reg(ccpt_pkg::CNT_OFS, v); check({15'h0, v <= 16'h0007}, 16'h0001);
      end
      rd_reg(ccpt_pkg::STAT_OFS, v); check(v & 16'h0001, 16'h0001);
      check({15'h0, irq}, 16'h0001);
      for (int c = 2; c >= 0; c--) begin
         v = (c == 0) ? 16'h0031 : ((c == 2) ? 16'h0021 : 16'h0011);
         wr_reg(ccpt_pkg::IO0_OFS, v);
         repeat (20) @(posedge clk_i);
         watch(32, hi, fl);
         check({15'h0, oe_n[1]}, 16'h0000);
         check(16'(fl), (c == 0) ? 16'h0004 : 16'h0000);
         check(16'(hi), (c == 2) ? 16'h0020 : ((c == 1) ? 16'h0000 : 16'h0010));
      end
      wr_reg(ccpt_pkg::CTRL_OFS, 16'h0000);
      wr_reg(ccpt_pkg::MODE_OFS, 16'h00e0);
      for (int e = 4; e <= 6; e++) begin
         wr_reg(ccpt_pkg::IO0_OFS, 16'h0040 | 16'(e));
         repeat (3) @(posedge clk_i);
         #1;
         check({15'h0, oe_n[1]}, 16'h0001);
         rd_reg(ccpt_pkg::GR_A_OFS, a0);
         @(posedge clk_i);
         cap <= 1'b1;
         repeat (3) @(posedge clk_i);
         rd_reg(ccpt_pkg::GR_A_OFS, a1); check({15'h0, a1 !== a0}, {15'h0, e != 5});
         rd_reg(ccpt_pkg::GR_C_OFS, v);
         if (e != 5) check(v, a0);
         @(posedge clk_i);
         cap <= 1'b0;
         repeat (3) @(posedge clk_i);
         rd_reg(ccpt_pkg::GR_A_OFS, v); check({15'h0, v !== a1}, {15'h0, e != 4});
      end
      // Capture code left in pin B's field: PWM must override it
      wr_reg(ccpt_pkg::MODE_OFS, 16'h0040);
      wr_reg(ccpt_pkg::CTRL_OFS, 16'h0082);
      wr_reg(ccpt_pkg::GR_A_OFS, 16'h0009);
      wr_reg(ccpt_pkg::GR_B_OFS, 16'h0004);
      wr_reg(ccpt_pkg::GR_C_OFS, 16'h0009);
      wr_reg(ccpt_pkg::CNT_OFS, 16'h0000);
      wr_reg(ccpt_pkg::MODE_OFS, 16'h00c7);
      for (int l = 0; l < 2; l++) begin
         repeat (20) @(posedge clk_i);
         watch(20, hi, fl);
         check({15'h0, oe_n[1]}, 16'h0000);
         check(16'(hi), 16'h000a);
         check(16'(fl), 16'h0004);
         // Level after the read edge follows the counter value one step on
         rd_reg(ccpt_pkg::CNT_OFS, v);
         check({15'h0, pin_o[1]}, {15'h0, (v == 16'h0009 || v <= 16'h0003) ^ (l != 0)});
         wr_reg(ccpt_pkg::CTRL_OFS, 16'h0080);
      end
      wr_reg(ccpt_pkg::GR_B_OFS, 16'h0009);
      repeat (20) @(posedge clk_i);
      watch(20, hi, fl); check(16'(fl), 16'h0000);
      wr_reg(ccpt_pkg::GR_B_OFS, 16'h0004);
      wr_reg(ccpt_pkg::GR_D_OFS, 16'h0002);
      wr_reg(ccpt_pkg::MODE_OFS, 16'h00d1);
      repeat (25) @(posedge clk_i);
      rd_reg(ccpt_pkg::GR_B_OFS, v); check(v, 16'h0002);
      wr_reg(ccpt_pkg::MODE_OFS, 16'h0080);
      repeat (3) @(posedge clk_i);
      #1;
      check({15'h0, oe_n[1]}, 16'h0000);
      wr_reg(ccpt_pkg::ODIS_OFS, 16'h000f);
      repeat (3) @(posedge clk_i);
      #1;
      check({12'h000, oe_n}, 16'h000f);
      final_report();
   end
endmodule

// ===== dv/ccpt_pin_model.sv
`timescale 1ns/10ps
module ccpt_pin_model (
   input  wire logic       cap_lvl_i,
   input  wire logic [3:0] pin_o_i,
   input  wire logic [3:0] oe_n_i,
   output logic      [3:0] pin_level_o
);
   // Undriven pins B-D rest on a pull-up and undriven pin A follows cap_lvl_i, so a released pin never keeps a stale level
   always_comb begin
      pin_level_o = 4'hf;
      pin_level_o[0] = cap_lvl_i;
      for (int k = 0; k < 4; k++) begin
         if (!oe_n_i[k]) begin
            pin_level_o[k] = pin_o_i[k];
         end
      end
   end
endmodule

// ===== hw/ccpt_pkg.sv
package ccpt_pkg;
   // Register offsets on the plain register port
   localparam logic [3:0]  MODE_OFS    = 4'h0;
   localparam logic [3:0]  CTRL_OFS    = 4'h1;
   localparam logic [3:0]  IEN_OFS     = 4'h2;
   localparam logic [3:0]  STAT_OFS    = 4'h3;
   localparam logic [3:0]  IO0_OFS     = 4'h4;
   localparam logic [3:0]  IO1_OFS     = 4'h5;
   localparam logic [3:0]  ODIS_OFS    = 4'h6;
   localparam logic [3:0]  CNT_OFS     = 4'h7;
   localparam logic [3:0]  GR_A_OFS    = 4'h8;
   localparam logic [3:0]  GR_B_OFS    = 4'h9;
   localparam logic [3:0]  GR_C_OFS    = 4'ha;
   localparam logic [3:0]  GR_D_OFS    = 4'hb;

   // timer_mode_reg fields
   localparam int          MODE_RUN_BIT  = 7;
   localparam int          MODE_SPM_BIT  = 6;
   localparam int          MODE_BUFA_BIT = 5;
   localparam int          MODE_BUFB_BIT = 4;
   localparam int          MODE_PWM_LSB  = 0;
   // control_reg_1 fields
   localparam int          CTRL_CLR_BIT  = 7;
   localparam int          CTRL_LVL_LSB  = 0;
   // Status and enable layout: match flags in [3:0], overflow in bit 7
   localparam int          STAT_OVF_BIT  = 7;
   localparam int          STAT_MATCH_LSB = 0;
   // io_control_reg_0/1: low field pin A/C, high field pin B/D
   localparam int          IO_LO_LSB     = 0;
   localparam int          IO_HI_LSB     = 4;

   // I/O field encodings
   localparam logic [2:0]  IO_OUT_LOW    = 3'h1;
   localparam logic [2:0]  IO_OUT_HIGH   = 3'h2;
   localparam logic [2:0]  IO_OUT_TOGGLE = 3'h3;
   localparam logic [1:0]  EDGE_RISE     = 2'h0;
   localparam logic [1:0]  EDGE_FALL     = 2'h1;

   // Reset values
   localparam logic [15:0] MODE_RST      = 16'h0040;
   localparam logic [15:0] ODIS_RST      = 16'h000f;
   localparam logic [15:0] GR_RST        = 16'hffff;
   localparam logic [15:0] CNT_RST       = 16'h0000;
   localparam logic [15:0] CNT_TOP       = 16'hffff;
   localparam logic [15:0] ZERO_RST      = 16'h0000;

   typedef enum logic [2:0] {
      CCPT_FN_PORT,
      CCPT_FN_CMP,
      CCPT_FN_CAP,
      CCPT_FN_PWM,
      CCPT_FN_SPM
   } ccpt_fn_e;
endpackage

// ===== hw/ccpt_timer.sv
// Operation
// - Pin B single-pulse output when single-pulse bit clear
// - PWM bit selects PWM waveform, ignoring I/O field
// - I/O field 001/01X gives compare output
// - I/O field 1XX gives input capture
// - Disabled or unmatched pin is general port
// - Stopped after reset, counts once run set
// - Wrap FFFF to 0000 sets overflow flag
// - Clear-on-match-A restarts counter from zero
// - Compare match drives 0, 1 or toggle
// - Pin already at level stays unchanged
// - Capture on A/B stores counter on selected edge
// - Capture A shifts old A into C
// - Register A cycle, B/C/D duty in PWM
// - PWM forces compare role, ignores I/O fields
// - Level-set bit chooses PWM edge polarity
// - Duty equal to cycle leaves pin unchanged
// - Buffered PWM B copies D into B
`timescale 1ns/10ps
module ccpt_timer #(
   parameter int DW = 16,
   parameter int AW = 4
) (
   input  wire logic          clk_i,
   input  wire logic          rst_n_i,
   input  wire logic [AW-1:0] reg_addr_i,
   input  wire logic [DW-1:0] reg_wdata_i,
   input  wire logic          reg_wr_i,
   input  wire logic          reg_rd_i,
   output logic      [DW-1:0] reg_rdata_o,
   input  wire logic [3:0]    timer_pin_i,
   output logic      [3:0]    timer_pin_o,
   output logic      [3:0]    timer_pin_oe_n_o,
   output logic               irq_o
);
   logic [15:0] timer_mode_reg_q, timer_mode_reg_d;
   logic [15:0] control_reg_1_q, control_reg_1_d;
   logic [15:0] irq_enable_reg_q, irq_enable_reg_d;
   logic [15:0] timer_status_reg_q, timer_status_reg_d;
   logic [15:0] io_control_reg_0_q, io_control_reg_0_d;
   logic [15:0] io_control_reg_1_q, io_control_reg_1_d;
   logic [15:0] timer_output_disable_reg_q, timer_output_disable_reg_d;
   logic [15:0] main_counter_q, main_counter_d;
   logic [15:0] gr_q [4];
   logic [15:0] gr_d [4];
   logic [3:0]  lvl_q, lvl_d;
   logic [3:0]  oe_n_q, oe_n_d;
   logic [3:0]  prev_q;
   logic [DW-1:0] rdata_q, rdata_d;
   logic        irq_q, irq_d;

   logic                  count_run;
   logic                  single_pulse_mode_bit;
   logic                  clear_on_match_a;
   logic [3:0]            pwm_bits;
   logic [3:0]            lvl_set;
   logic [1:0]            buf_en;
   logic [2:0]            io_f [4];
   ccpt_pkg::ccpt_fn_e    fn [4];
   logic [3:0]            match;
   logic [3:0]            cap_ev;
   logic [3:0]            cmp_role;
   logic                  wr_cnt;
   logic                  count_step;
   logic                  clear_a;
   logic                  overflow_ev;

   assign count_run             = timer_mode_reg_q[ccpt_pkg::MODE_RUN_BIT];
   assign single_pulse_mode_bit = timer_mode_reg_q[ccpt_pkg::MODE_SPM_BIT];
   assign buf_en   = {timer_mode_reg_q[ccpt_pkg::MODE_BUFB_BIT], timer_mode_reg_q[ccpt_pkg::MODE_BUFA_BIT]};
   // Pin A has no PWM bit
   assign pwm_bits = {timer_mode_reg_q[ccpt_pkg::MODE_PWM_LSB +: 3], 1'b0};
   assign clear_on_match_a = control_reg_1_q[ccpt_pkg::CTRL_CLR_BIT];
   assign lvl_set  = control_reg_1_q[ccpt_pkg::CTRL_LVL_LSB +: 4];
   assign io_f[0]  = io_control_reg_0_q[ccpt_pkg::IO_LO_LSB +: 3];
   assign io_f[1]  = io_control_reg_0_q[ccpt_pkg::IO_HI_LSB +: 3];
   assign io_f[2]  = io_control_reg_1_q[ccpt_pkg::IO_LO_LSB +: 3];
   assign io_f[3]  = io_control_reg_1_q[ccpt_pkg::IO_HI_LSB +: 3];

   // A software write to the counter takes precedence over counting
   assign wr_cnt     = reg_wr_i && (reg_addr_i == ccpt_pkg::CNT_OFS);
   assign count_step = count_run && !wr_cnt;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ch
         always_comb begin
            if (timer_output_disable_reg_q[g]) begin
               fn[g] = ccpt_pkg::CCPT_FN_PORT;
            end else if (!single_pulse_mode_bit) begin
               fn[g] = (g == 1) ? ccpt_pkg::CCPT_FN_SPM : ccpt_pkg::CCPT_FN_PORT;
            end else if (pwm_bits[g]) begin
               fn[g] = ccpt_pkg::CCPT_FN_PWM;
            end else if (io_f[g] == ccpt_pkg::IO_OUT_LOW || io_f[g][2:1] == 2'h1) begin
               fn[g] = ccpt_pkg::CCPT_FN_CMP;
            end else if (io_f[g][2]) begin
               fn[g] = ccpt_pkg::CCPT_FN_CAP;
            end else begin
               fn[g] = ccpt_pkg::CCPT_FN_PORT;
            end
         end
         // Match is taken as the counter leaves the matching value
         assign match[g] = count_step && (main_counter_q == gr_q[g]);
         assign cap_ev[g] = (fn[g] == ccpt_pkg::CCPT_FN_CAP) &&
                            ((io_f[g][1:0] == ccpt_pkg::EDGE_RISE) ? (timer_pin_i[g] && !prev_q[g]) :
                             (io_f[g][1:0] == ccpt_pkg::EDGE_FALL) ? (!timer_pin_i[g] && prev_q[g]) :
                             (timer_pin_i[g] != prev_q[g]));
      end
   endgenerate

   // register A compares whenever any pin runs PWM or single-pulse
   assign cmp_role[0] = (fn[0] == ccpt_pkg::CCPT_FN_CMP) || (fn[1] == ccpt_pkg::CCPT_FN_PWM) ||
                        (fn[2] == ccpt_pkg::CCPT_FN_PWM) || (fn[3] == ccpt_pkg::CCPT_FN_PWM) ||
                        (fn[1] == ccpt_pkg::CCPT_FN_SPM);
   assign cmp_role[1] = (fn[1] == ccpt_pkg::CCPT_FN_CMP) || (fn[1] == ccpt_pkg::CCPT_FN_PWM) ||
                        (fn[1] == ccpt_pkg::CCPT_FN_SPM);
   assign cmp_role[2] = (fn[2] == ccpt_pkg::CCPT_FN_CMP) || (fn[2] == ccpt_pkg::CCPT_FN_PWM) ||
                        (fn[1] == ccpt_pkg::CCPT_FN_SPM);
   assign cmp_role[3] = (fn[3] == ccpt_pkg::CCPT_FN_CMP) || (fn[3] == ccpt_pkg::CCPT_FN_PWM);

   assign clear_a     = clear_on_match_a && cmp_role[0] && match[0];
   assign overflow_ev = count_step && (main_counter_q == ccpt_pkg::CNT_TOP) && !clear_a;

   // Counter and waveform state
   always_comb begin
      main_counter_d = main_counter_q;
      lvl_d          = lvl_q;
      oe_n_d         = oe_n_q;
      for (int i = 0; i < 4; i++) begin
         gr_d[i] = gr_q[i];
      end
      if (wr_cnt) begin
         main_counter_d = reg_wdata_i[15:0];
      end else if (clear_a) begin
         main_counter_d = ccpt_pkg::CNT_RST;
      end else if (count_step) begin
         main_counter_d = main_counter_q + 16'h0001;
      end
      for (int i = 0; i < 4; i++) begin
         oe_n_d[i] = !((fn[i] == ccpt_pkg::CCPT_FN_CMP) || (fn[i] == ccpt_pkg::CCPT_FN_PWM) ||
                       (fn[i] == ccpt_pkg::CCPT_FN_SPM));
         case (fn[i])
            ccpt_pkg::CCPT_FN_CMP: begin
               // 0, 1 or toggle; setting an equal level changes nothing
               if (match[i]) begin
                  case (io_f[i])
                     ccpt_pkg::IO_OUT_LOW:    lvl_d[i] = 1'b0;
                     ccpt_pkg::IO_OUT_HIGH:   lvl_d[i] = 1'b1;
                     ccpt_pkg::IO_OUT_TOGGLE: lvl_d[i] = !lvl_q[i];
                     default:                 lvl_d[i] = lvl_q[i];
                  endcase
               end
            end
            ccpt_pkg::CCPT_FN_PWM: begin
               // A sets cycle, own register sets duty
               // equal duty and cycle freeze the pin
               if (gr_q[i] != gr_q[0]) begin
                  if (match[0]) begin
                     lvl_d[i] = lvl_set[i];
                  end else if (match[i]) begin
                     lvl_d[i] = !lvl_set[i];
                  end
               end
            end
            ccpt_pkg::CCPT_FN_SPM: begin
               // B starts the pulse, C ends it
               if (match[1]) begin
                  lvl_d[i] = lvl_set[1];
               end else if (match[2]) begin
                  lvl_d[i] = !lvl_set[1];
               end
            end
            default: lvl_d[i] = lvl_q[i];
         endcase
      end
      // Buffer pairs: C behind A, D behind B
      for (int j = 0; j < 2; j++) begin
         if (cap_ev[j]) begin
            // buffered capture shifts old value out
            if (buf_en[j]) begin
               gr_d[j + 2] = gr_q[j];
            end
            gr_d[j] = main_counter_q;
         end else if (buf_en[j] && cmp_role[j] && match[j] && fn[1] != ccpt_pkg::CCPT_FN_SPM) begin
            gr_d[j] = gr_q[j + 2];
         end
      end
      if (fn[1] == ccpt_pkg::CCPT_FN_SPM && buf_en[1] && match[0]) begin
         gr_d[1] = gr_q[3];
      end
      // Software writes win over hardware updates of the same register
      if (reg_wr_i) begin
         case (reg_addr_i)
            ccpt_pkg::GR_A_OFS: gr_d[0] = reg_wdata_i[15:0];
            ccpt_pkg::GR_B_OFS: gr_d[1] = reg_wdata_i[15:0];
            ccpt_pkg::GR_C_OFS: gr_d[2] = reg_wdata_i[15:0];
            ccpt_pkg::GR_D_OFS: gr_d[3] = reg_wdata_i[15:0];
            default:            gr_d[0] = gr_d[0];
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         main_counter_q <= ccpt_pkg::CNT_RST;
         lvl_q          <= 4'h0;
         oe_n_q         <= 4'hf;
         prev_q         <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            gr_q[i] <= ccpt_pkg::GR_RST;
         end
      end else begin
         main_counter_q <= main_counter_d;
         lvl_q          <= lvl_d;
         oe_n_q         <= oe_n_d;
         prev_q         <= timer_pin_i;
         for (int i = 0; i < 4; i++) begin
            gr_q[i] <= gr_d[i];
         end
      end
   end

   // Register file, status and interrupt
   always_comb begin
      timer_mode_reg_d           = timer_mode_reg_q;
      control_reg_1_d            = control_reg_1_q;
      irq_enable_reg_d           = irq_enable_reg_q;
      io_control_reg_0_d         = io_control_reg_0_q;
      io_control_reg_1_d         = io_control_reg_1_q;
      timer_output_disable_reg_d = timer_output_disable_reg_q;
      timer_status_reg_d         = timer_status_reg_q;
      rdata_d                    = '0;
      if (reg_wr_i) begin
         if (reg_addr_i == ccpt_pkg::MODE_OFS) begin
            timer_mode_reg_d = reg_wdata_i[15:0] & 16'h00f7;
         end else if (reg_addr_i == ccpt_pkg::CTRL_OFS) begin
            control_reg_1_d = reg_wdata_i[15:0] & 16'h008f;
         end else if (reg_addr_i == ccpt_pkg::IEN_OFS) begin
            irq_enable_reg_d = reg_wdata_i[15:0] & 16'h008f;
         end else if (reg_addr_i == ccpt_pkg::STAT_OFS) begin
            timer_status_reg_d = timer_status_reg_q & ~reg_wdata_i[15:0];
         end else if (reg_addr_i == ccpt_pkg::IO0_OFS) begin
            io_control_reg_0_d = reg_wdata_i[15:0] & 16'h0077;
         end else if (reg_addr_i == ccpt_pkg::IO1_OFS) begin
            io_control_reg_1_d = reg_wdata_i[15:0] & 16'h0077;
         end else if (reg_addr_i == ccpt_pkg::ODIS_OFS) begin
            timer_output_disable_reg_d = reg_wdata_i[15:0] & 16'h000f;
         end
      end
      // overflow flag; a set in the clearing cycle wins
      if (overflow_ev) begin
         timer_status_reg_d[ccpt_pkg::STAT_OVF_BIT] = 1'b1;
      end
      for (int i = 0; i < 4; i++) begin
         // match flag on compare or capture
         if ((cmp_role[i] && match[i]) || cap_ev[i]) begin
            timer_status_reg_d[ccpt_pkg::STAT_MATCH_LSB + i] = 1'b1;
         end
      end
      irq_d = |(timer_status_reg_d & irq_enable_reg_d);
      if (reg_rd_i) begin
         if (reg_addr_i == ccpt_pkg::MODE_OFS) begin
            rdata_d = timer_mode_reg_q;
         end else if (reg_addr_i == ccpt_pkg::CTRL_OFS) begin
            rdata_d = control_reg_1_q;
         end else if (reg_addr_i == ccpt_pkg::IEN_OFS) begin
            rdata_d = irq_enable_reg_q;
         end else if (reg_addr_i == ccpt_pkg::STAT_OFS) begin
            rdata_d = timer_status_reg_q;
         end else if (reg_addr_i == ccpt_pkg::IO0_OFS) begin
            rdata_d = io_control_reg_0_q;
         end else if (reg_addr_i == ccpt_pkg::IO1_OFS) begin
            rdata_d = io_control_reg_1_q;
         end else if (reg_addr_i == ccpt_pkg::ODIS_OFS) begin
            rdata_d = timer_output_disable_reg_q;
         end else if (reg_addr_i == ccpt_pkg::CNT_OFS) begin
            // counter is read as one whole word
            rdata_d = main_counter_q;
         end else if (reg_addr_i == ccpt_pkg::GR_A_OFS) begin
            rdata_d = gr_q[0];
         end else if (reg_addr_i == ccpt_pkg::GR_B_OFS) begin
            rdata_d = gr_q[1];
         end else if (reg_addr_i == ccpt_pkg::GR_C_OFS) begin
            rdata_d = gr_q[2];
         end else if (reg_addr_i == ccpt_pkg::GR_D_OFS) begin
            rdata_d = gr_q[3];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_mode_reg_q           <= ccpt_pkg::MODE_RST;
         control_reg_1_q            <= ccpt_pkg::ZERO_RST;
         irq_enable_reg_q           <= ccpt_pkg::ZERO_RST;
         timer_status_reg_q         <= ccpt_pkg::ZERO_RST;
         io_control_reg_0_q         <= ccpt_pkg::ZERO_RST;
         io_control_reg_1_q         <= ccpt_pkg::ZERO_RST;
         timer_output_disable_reg_q <= ccpt_pkg::ODIS_RST;
         rdata_q                    <= '0;
         irq_q                      <= 1'b0;
      end else begin
         timer_mode_reg_q           <= timer_mode_reg_d;
         control_reg_1_q            <= control_reg_1_d;
         irq_enable_reg_q           <= irq_enable_reg_d;
         timer_status_reg_q         <= timer_status_reg_d;
         io_control_reg_0_q         <= io_control_reg_0_d;
         io_control_reg_1_q         <= io_control_reg_1_d;
         timer_output_disable_reg_q <= timer_output_disable_reg_d;
         rdata_q                    <= rdata_d;
         irq_q                      <= irq_d;
      end
   end

   assign reg_rdata_o      = rdata_q;
   assign timer_pin_o      = lvl_q;
   assign timer_pin_oe_n_o = oe_n_q;
   assign irq_o            = irq_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_count_hold_idle: assert property (!count_run && !wr_cnt |=> $stable(main_counter_q))
      else $error("counter moved while stopped");
   a_overflow_flag: assert property (count_run && !wr_cnt && main_counter_q == 16'hffff && !clear_a
                                     |=> main_counter_q == 16'h0000 && timer_status_reg_q[7])
      else $error("wrap did not set overflow");
   a_periodic_clear: assert property (clear_a && !wr_cnt |=> main_counter_q == 16'h0000 ##1
                                      main_counter_q == (count_run ? 16'h0001 : 16'h0000) || $past(reg_wr_i))
      else $error("match A did not restart counter");
   a_cmp_low_level: assert property (fn[2] == ccpt_pkg::CCPT_FN_CMP && io_f[2] == 3'h1 && match[2]
                                     |=> timer_pin_o[2] == 1'b0 && !timer_pin_oe_n_o[2])
      else $error("compare C did not drive low");
   a_port_released: assert property (timer_output_disable_reg_q[3] |=> timer_pin_oe_n_o[3])
      else $error("disabled pin D still driven");
   a_single_pulse_b: assert property (!timer_output_disable_reg_q[1] && !single_pulse_mode_bit
                                      |=> !timer_pin_oe_n_o[1])
      else $error("pin B not driven in single-pulse mode");
   a_capture_value: assert property (cap_ev[1] && !reg_wr_i |=> gr_q[1] == $past(main_counter_q))
      else $error("capture B stored wrong value");
   a_capture_buffer: assert property (cap_ev[0] && buf_en[0] && !reg_wr_i
                                      |=> gr_q[2] == $past(gr_q[0]) && gr_q[0] == $past(main_counter_q))
      else $error("buffered capture A wrong");
   a_pwm_cycle_edge: assert property (fn[3] == ccpt_pkg::CCPT_FN_PWM && match[0] && gr_q[3] != gr_q[0]
                                      |=> timer_pin_o[3] == $past(lvl_set[3]))
      else $error("PWM D wrong level at cycle match");
   a_pwm_equal_hold: assert property (fn[2] == ccpt_pkg::CCPT_FN_PWM && gr_q[2] == gr_q[0]
                                      |=> $stable(timer_pin_o[2]))
      else $error("PWM C changed with equal duty");
   a_pwm_buffer_b: assert property (fn[1] == ccpt_pkg::CCPT_FN_PWM && buf_en[1] && match[1] && !reg_wr_i
                                    |=> gr_q[1] == $past(gr_q[3]))
      else $error("PWM B buffer not copied");
endmodule
